//--- hdl/bkreg_pkg.sv
// Purpose: Constants for the buck channel control register bank
// Assumes: Byte-wide registers at the printed offsets
// Notes:   Millivolt figures feed the voltage-code decoder
package bkreg_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] STANDBY_VOLTAGE_CODE_OFS   = 8'h20;
  localparam logic [7:0] RESERVED_READONLY_OFS      = 8'h21;
  localparam logic [7:0] CHANNEL_CONTROL_STATUS_OFS = 8'h22;
  localparam logic [7:0] VOLTAGE_CODE_AND_RANGE_OFS = 8'h23;
  localparam int unsigned CODE_W                    = 6;
  localparam int unsigned ENABLE_BIT                = 0;
  localparam int unsigned POWER_GOOD_BIT            = 1;
  localparam int unsigned FAULT_UNMASK_BIT          = 2;
  localparam int unsigned RANGE_SELECT_BIT          = 6;
  // ---------------------------------------------------------------
  // Reset values and read-only fill
  // ---------------------------------------------------------------
  localparam logic [5:0] CODE_RST      = 6'h00;
  localparam logic       ENABLE_RST    = 1'b0;
  localparam logic       UNMASK_RST    = 1'b0;
  localparam logic       RANGE_RST     = 1'b0;
  localparam logic [7:0] RO_FILL       = 8'h00;
  // ---------------------------------------------------------------
  // Voltage encoding, millivolts
  // ---------------------------------------------------------------
  localparam logic [12:0] LOW_BASE_MV  = 13'd625;
  localparam logic [12:0] LOW_STEP_MV  = 13'd25;
  localparam logic [12:0] LOW_MIN_MV   = 13'd800;
  localparam logic [5:0]  LOW_FLOOR_N  = 6'h08;
  localparam logic [5:0]  ODD_CODE     = 6'h22;
  localparam logic [12:0] ODD_MV       = 13'd1480;
  localparam logic [12:0] HIGH_BASE_MV = 13'd1250;
  localparam logic [12:0] HIGH_STEP_MV = 13'd50;
  localparam logic [5:0]  ADJ_CODE     = 6'h00;
endpackage

//--- hdl/bkreg_if.sv
// Purpose: Carries voltage code and range to the decoder
// Assumes: Single clock domain
// Notes:   Decoder answers combinationally
`timescale 1ns/10ps
interface bkreg_if;
  logic [5:0]  code;
  logic        range_sel;
  logic [12:0] mv;
  logic        adjustable;
  modport ctrl (output code, output range_sel, input mv, input adjustable);
  modport dec  (input code, input range_sel, output mv, output adjustable);
endinterface

//--- hdl/bkreg_vdec.sv
// Purpose: Maps a six-bit voltage code and range to a target in mV
// Assumes: Codes are those held by the register bank
// Notes:   Code 0 means adjustable mode, target reads zero
`timescale 1ns/10ps
module bkreg_vdec (
  // Code in, target out
  bkreg_if.dec vif
);
  always_comb begin
    vif.adjustable = (vif.code == bkreg_pkg::ADJ_CODE);
    vif.mv = 13'h0000;
    if (vif.adjustable) begin
      vif.mv = 13'h0000;
    end else if (vif.range_sel) begin
      vif.mv = bkreg_pkg::HIGH_BASE_MV
             + 13'(bkreg_pkg::HIGH_STEP_MV * 13'(vif.code)); // [RULE10]
    end else if (vif.code == bkreg_pkg::ODD_CODE) begin
      vif.mv = bkreg_pkg::ODD_MV; // [RULE9]
    end else if (vif.code < bkreg_pkg::LOW_FLOOR_N) begin
      vif.mv = bkreg_pkg::LOW_MIN_MV; // [RULE9]
    end else begin
      vif.mv = bkreg_pkg::LOW_BASE_MV
             + 13'(bkreg_pkg::LOW_STEP_MV * 13'(vif.code)); // [RULE9]
    end
  end
endmodule

//--- hdl/bkreg_top.sv
// Operation
// [RULE1] Standby code, bits 5:0 at 0x20
// [RULE2] Normal code, bits 5:0 at 0x23
// [RULE3] Read-only bits ignore writes
// [RULE4] Bit 0 at 0x22 enables channel
// [RULE5] Bit 1 at 0x22 shows power good
// [RULE6] Bit 2 at 0x22: 0 masks faults
// [RULE7] Bit 6 at 0x23 selects range
// [RULE8] Range picks low or high span
// [RULE9] Low range: 625mV plus 25mV steps
// [RULE10] High range: 1250mV plus 50mV steps
// [RULE11] Host checks range before switching it
// [RULE12] Serial-bus writes apply channel settings
//
// Purpose: Register bank for the second buck channel
// Assumes: Serial front end gives byte strobes synchronous to clock
// Notes:   Standby select picks which code drives the target
`timescale 1ns/10ps
module bkreg_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Register access from serial front end
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // Converter status and mode
  input  wire logic        power_good_i,
  input  wire logic        standby_i,
  // Converter controls
  output logic             enable_o,
  output logic             fault_unmask_o,
  output logic             range_select_o,
  output logic      [5:0]  voltage_select_code_o,
  output logic      [12:0] target_mv_o,
  output logic             adjustable_o
);
  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic [5:0]  standby_voltage_code_q, standby_voltage_code_d;
  logic [5:0]  normal_voltage_code_q,  normal_voltage_code_d;
  logic        range_select_q,         range_select_d;
  logic        enable_q,               enable_d;
  logic        fault_unmask_q,         fault_unmask_d;
  logic [7:0]  rdata_q,                rdata_d;
  logic        rvalid_q,               rvalid_d;
  logic [5:0]  code_q,                 code_d;
  logic [12:0] mv_q,                   mv_d;
  logic        adj_q,                  adj_d;

  bkreg_if vif ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  always_comb begin
    standby_voltage_code_d = standby_voltage_code_q;
    normal_voltage_code_d  = normal_voltage_code_q;
    range_select_d         = range_select_q;
    enable_d               = enable_q;
    fault_unmask_d         = fault_unmask_q;
    if (reg_wr_i) begin // [RULE12]
      if (hit(reg_addr_i, bkreg_pkg::STANDBY_VOLTAGE_CODE_OFS)) begin
        standby_voltage_code_d = reg_wdata_i[bkreg_pkg::CODE_W-1:0]; // [RULE1]
      end
      if (hit(reg_addr_i, bkreg_pkg::CHANNEL_CONTROL_STATUS_OFS)) begin
        enable_d       = reg_wdata_i[bkreg_pkg::ENABLE_BIT]; // [RULE4]
        fault_unmask_d = reg_wdata_i[bkreg_pkg::FAULT_UNMASK_BIT]; // [RULE6]
      end
      if (hit(reg_addr_i, bkreg_pkg::VOLTAGE_CODE_AND_RANGE_OFS)) begin
        normal_voltage_code_d = reg_wdata_i[bkreg_pkg::CODE_W-1:0]; // [RULE2]
        range_select_d = reg_wdata_i[bkreg_pkg::RANGE_SELECT_BIT]; // [RULE7]
      end
      // Other bits and 0x21 have no storage, so writes fall away [RULE3]
    end
  end

  // ---------------------------------------------------------------
  // Read path, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d  = bkreg_pkg::RO_FILL; // [RULE3]
    rvalid_d = reg_rd_i;
    if (hit(reg_addr_i, bkreg_pkg::STANDBY_VOLTAGE_CODE_OFS)) begin
      rdata_d[bkreg_pkg::CODE_W-1:0] = standby_voltage_code_q;
    end else if (hit(reg_addr_i, bkreg_pkg::CHANNEL_CONTROL_STATUS_OFS)) begin
      rdata_d[bkreg_pkg::ENABLE_BIT]       = enable_q;
      rdata_d[bkreg_pkg::POWER_GOOD_BIT]   = power_good_i; // [RULE5]
      rdata_d[bkreg_pkg::FAULT_UNMASK_BIT] = fault_unmask_q;
    end else if (hit(reg_addr_i, bkreg_pkg::VOLTAGE_CODE_AND_RANGE_OFS)) begin
      rdata_d[bkreg_pkg::CODE_W-1:0] = normal_voltage_code_q;
      rdata_d[bkreg_pkg::RANGE_SELECT_BIT] = range_select_q;
    end
    if (!reg_rd_i) begin
      rdata_d = rdata_q;
    end
  end

  // ---------------------------------------------------------------
  // Target voltage, registered so outputs stay glitch free
  // ---------------------------------------------------------------
  assign vif.code      = standby_i ? standby_voltage_code_q
                                   : normal_voltage_code_q;
  assign vif.range_sel = range_select_q; // [RULE8]

  bkreg_vdec u_vdec (
    .vif (vif.dec)
  );

  always_comb begin
    code_d = vif.code;
    mv_d   = vif.mv;
    adj_d  = vif.adjustable;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      standby_voltage_code_q <= bkreg_pkg::CODE_RST;
      normal_voltage_code_q  <= bkreg_pkg::CODE_RST;
      range_select_q         <= bkreg_pkg::RANGE_RST;
      enable_q               <= bkreg_pkg::ENABLE_RST;
      fault_unmask_q         <= bkreg_pkg::UNMASK_RST;
      rdata_q                <= bkreg_pkg::RO_FILL;
      rvalid_q               <= 1'b0;
      code_q                 <= bkreg_pkg::CODE_RST;
      mv_q                   <= 13'h0000;
      adj_q                  <= 1'b1;
    end else begin
      standby_voltage_code_q <= standby_voltage_code_d;
      normal_voltage_code_q  <= normal_voltage_code_d;
      range_select_q         <= range_select_d;
      enable_q               <= enable_d;
      fault_unmask_q         <= fault_unmask_d;
      rdata_q                <= rdata_d;
      rvalid_q               <= rvalid_d;
      code_q                 <= code_d;
      mv_q                   <= mv_d;
      adj_q                  <= adj_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o           = rdata_q;
  assign reg_rvalid_o          = rvalid_q;
  assign enable_o              = enable_q;
  assign fault_unmask_o        = fault_unmask_q;
  assign range_select_o        = range_select_q;
  assign voltage_select_code_o = code_q;
  assign target_mv_o           = mv_q;
  assign adjustable_o          = adj_q;
endmodule

//--- bench/bkreg_top_props.sv
// Purpose: Port assertions for the buck register bank
// Assumes: One clock, synchronous reset
// Notes:   Bound into every bkreg_top
`timescale 1ns/10ps
module bkreg_chk (
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       power_good_i,
  input wire logic       standby_i,
  input wire logic       enable_o,
  input wire logic       fault_unmask_o,
  input wire logic       range_select_o,
  input wire logic [5:0] voltage_select_code_o,
  input wire logic       adjustable_o
);
  wire w22 = reg_wr_i && reg_addr_i == 8'h22;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  chk_read_answer: assert property (
    reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  chk_no_stray: assert property (
    !reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
  chk_enable_bit: assert property (
    w22 |=> enable_o == $past(reg_wdata_i[0])) else $error("enable bit");
  chk_unmask_bit: assert property (
    w22 |=> fault_unmask_o == $past(reg_wdata_i[2])) else $error("unmask");
  chk_range_bit: assert property (
    reg_wr_i && reg_addr_i == 8'h23 |=>
    range_select_o == $past(reg_wdata_i[6])) else $error("range bit");
  chk_good_flag: assert property (
    reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[1] == $past(power_good_i)
    && reg_rdata_o[7:3] == 5'h00) else $error("status byte");
  chk_ro_byte: assert property (
    reg_rd_i && reg_addr_i == 8'h21 |=> reg_rdata_o == 8'h00)
    else $error("read-only byte");
  chk_adj_code: assert property (
    adjustable_o == (voltage_select_code_o == 6'h00)) else $error("adjust");
  // Active code lags the register write by two edges
  chk_standby_code: assert property (
    reg_wr_i && reg_addr_i == 8'h20 ##1 standby_i |=>
    voltage_select_code_o == $past(reg_wdata_i[5:0], 2))
    else $error("standby code");
  chk_normal_code: assert property (
    reg_wr_i && reg_addr_i == 8'h23 ##1 !standby_i |=>
    voltage_select_code_o == $past(reg_wdata_i[5:0], 2))
    else $error("normal code");
endmodule
bind bkreg_top bkreg_chk u_chk (.sys_clk_i, .srst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .power_good_i,
  .standby_i, .enable_o, .fault_unmask_o, .range_select_o,
  .voltage_select_code_o, .adjustable_o);

//--- bench/bkreg_host.sv
// Purpose: Host model issuing byte reads and writes
// Assumes: Strobes move 1 ns after the rising edge
// Notes:   Released address and data show inverted values
`timescale 1ns/10ps
module bkreg_host (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1 {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(posedge sys_clk_i);
    #1 {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  // Missing answer yields unknown data so the compare fails
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1 {rd_o, addr_o} = {1'b1, a};
    @(posedge sys_clk_i);
    #1 {rd_o, addr_o} = {1'b0, ~a};
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule

//--- bench/tb_bkreg_top.sv
// Purpose: Self-checking bench for the buck register bank
// Assumes: Host model drives all access strobes
// Notes:   Sweeps every code in both ranges
`timescale 1ns/10ps
module tb_bkreg_top;
  logic        sys_clk_i, srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic        power_good_i, standby_i, enable_o, fault_unmask_o;
  logic        range_select_o, adjustable_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [5:0]  voltage_select_code_o;
  logic [12:0] target_mv_o;
  int          err_total, n_compared, cyc;
  bkreg_top DUT (.sys_clk_i, .srst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .power_good_i, .standby_i,
    .enable_o, .fault_unmask_o, .range_select_o, .voltage_select_code_o,
    .target_mv_o, .adjustable_o);
  bkreg_host host (.sys_clk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i));
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    cmp({5'h00, d}, {5'h00, e});
  endtask
  // Low range floors codes 1..7 at 800 mV, 0x22 is an odd 1480 mV
  function automatic logic [12:0] mv_of(input logic r, input logic [5:0] n);
    if (n == 6'h00) return 13'h0000;
    if (r) return 13'h04e2 + 13'h0032 * n;
    if (n < 6'h08) return 13'h0320;
    if (n == 6'h22) return 13'h05c8;
    return 13'h0271 + 13'h0019 * n;
  endfunction
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // Run should end near 430 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {srst_i, power_good_i, standby_i} = 3'b100;
    {err_total, n_compared, cyc} = '0;
    repeat (2) @(posedge sys_clk_i);
    #1 srst_i = 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(8'h20 + i[7:0], 8'h00);
    host.wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h3f);
    host.wr(8'h21, 8'hff);
    rd_chk(8'h21, 8'h00);
    power_good_i = 1'b1;
    host.wr(8'h22, 8'hff);
    rd_chk(8'h22, 8'h07);
    cmp({11'h000, fault_unmask_o, enable_o}, 13'h0003);
    power_good_i = 1'b0;
    host.wr(8'h22, 8'h00);
    rd_chk(8'h22, 8'h00);
    host.wr(8'h23, 8'hff);
    rd_chk(8'h23, 8'h7f);
    host.wr(8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
    // Range follows bit 6 on every write to 0x23, whatever the code
    for (int r = 0; r < 2; r++) begin
      for (int n = 0; n < 64; n++) begin
        host.wr(8'h23, {1'b0, r[0], n[5:0]});
        cmp({12'h000, range_select_o}, {12'h000, r[0]});
        @(posedge sys_clk_i);
        #1 cmp(target_mv_o, mv_of(r[0], n[5:0]));
        cmp({12'h000, adjustable_o}, {12'h000, n == 0});
        cmp({7'h00, voltage_select_code_o}, {7'h00, n[5:0]});
      end
    end
    standby_i = 1'b1;
    host.wr(8'h20, 8'h0a);
    @(posedge sys_clk_i);
    #1 cmp(target_mv_o, 13'h06d6);
    // Reset in mid-run must return both codes, range, target and adjust flag to rest values
    srst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 srst_i = 1'b0;
    cmp({12'h000, adjustable_o}, 13'h0001);
    cmp(target_mv_o, 13'h0000);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h23, 8'h00);
    wrap_up();
  end
endmodule
